// ===== core/sfd_pkg.sv
package sfd_pkg;

  // ----------------------------------------
  // programming word layout
  // ----------------------------------------
  localparam int WORD_W = 24;
  localparam int CTRL_W = 3;
  localparam logic [2:0] CODE_FRAC = 3'h2;
  localparam logic [2:0] CODE_DITH = 3'h3;
  localparam logic [2:0] CODE_PUMP = 3'h4;

  // ----------------------------------------
  // fractional divide word
  // ----------------------------------------
  localparam int FRAC_LSB = 3;
  localparam int FRAC_W = 11;

  // ----------------------------------------
  // dither word
  // ----------------------------------------
  localparam int DV_LSB = 3;
  localparam int DV_W = 17;
  localparam int DEN_POS = 20;
  localparam int DMAG_LSB = 21;
  localparam int DMAG_W = 2;

  // ----------------------------------------
  // charge pump / reference word
  // ----------------------------------------
  localparam int MUX_LSB = 7;
  localparam int MUX_W = 3;
  localparam int MULT_LSB = 10;
  localparam int MULT_W = 2;
  localparam int OFS_LSB = 12;
  localparam int OFS_W = 5;
  localparam int SIGN_POS = 17;
  localparam int BIAS_RESISTOR_POS = 18;
  localparam int REF_LSB = 20;
  localparam int REF_W = 2;

  // ----------------------------------------
  // values after reset (whole words, code bits included)
  // ----------------------------------------
  localparam logic [23:0] FRAC_WORD_RST = 24'h001802;
  localparam logic [23:0] DITH_WORD_RST = 24'h10000b;
  localparam logic [23:0] PUMP_WORD_RST = 24'h100004;

  // ----------------------------------------
  // derived quantities
  // ----------------------------------------
  localparam logic [3:0] DMAG_TOP = 4'hf;
  localparam logic [7:0] OFS_STEP_TENTHS = 8'he1;
  localparam int PHASE_W = 13;
  localparam int SYNC_STAGES = 3;

  // reference scaling codes
  typedef enum logic [1:0] {
    SFD_REF_X2 = 2'h0,
    SFD_REF_X1 = 2'h1,
    SFD_REF_HALF = 2'h2,
    SFD_REF_QUARTER = 2'h3
  } sfd_ref_t;

  // status multiplexer sources
  typedef enum logic [2:0] {
    SFD_MUX_LOCK = 3'h0,
    SFD_MUX_HIGH = 3'h1,
    SFD_MUX_LOW = 3'h2,
    SFD_MUX_SIGN = 3'h3,
    SFD_MUX_EXTRES = 3'h4,
    SFD_MUX_DITHER = 3'h5,
    SFD_MUX_AUX = 3'h6,
    SFD_MUX_RANGE = 3'h7
  } sfd_mux_t;

endpackage

// ===== core/sfd_prog_rx.sv
`timescale 1ns/1ps
module sfd_prog_rx
  import sfd_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic prog_clk_i,
  input wire logic prog_data_i,
  input wire logic prog_latch_i,
  output logic [WORD_W-1:0] word_o,
  output logic word_valid_o
);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [SYNC_STAGES-1:0] sclk_q;
  logic [SYNC_STAGES-1:0] sdat_q;
  logic [SYNC_STAGES-1:0] slat_q;
  logic sclk_lvl_q;
  logic slat_lvl_q;
  logic [WORD_W-1:0] shift_q;

  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      sclk_q <= '0;
      sdat_q <= '0;
      slat_q <= '0;
    end
    else
    begin
      sclk_q <= {sclk_q[SYNC_STAGES-2:0], prog_clk_i};
      sdat_q <= {sdat_q[SYNC_STAGES-2:0], prog_data_i};
      slat_q <= {slat_q[SYNC_STAGES-2:0], prog_latch_i};
    end
  end

  // a level changes only when stages two and three agree
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      sclk_lvl_q <= 1'b0;
      slat_lvl_q <= 1'b0;
    end
    else
    begin
      if (sclk_q[1] == sclk_q[2])
        sclk_lvl_q <= sclk_q[2];
      if (slat_q[1] == slat_q[2])
        slat_lvl_q <= slat_q[2];
    end
  end

  // ----------------------------------------
  // shift register, msb first on rising serial clock
  // ----------------------------------------
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      shift_q <= '0;
    else if (sclk_q[1] == sclk_q[2] && sclk_q[2] && !sclk_lvl_q)
      shift_q <= {shift_q[WORD_W-2:0], sdat_q[2]};
  end

  // ----------------------------------------
  // rising latch hands the word over
  // ----------------------------------------
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      word_o <= '0;
      word_valid_o <= 1'b0;
    end
    else
    begin
      word_valid_o <= 1'b0;
      if (slat_q[1] == slat_q[2] && slat_q[2] && !slat_lvl_q)
      begin
        word_o <= shift_q;
        word_valid_o <= 1'b1;
      end
    end
  end

endmodule

// ===== core/sfd_regs.sv
// Behaviour
// - a word with control code 010 is loaded into the fractional divide control register.
// - a word with control code 011 is loaded into the dither control register.
// - bits 19..3 hold a 17-bit dither restart value that resets to one.
// - bit 20 turns dither off at 0 and on at 1, and resets to on.
// - a word with control code 100 is loaded into the charge pump and reference register.
// - bit 18 picks an internal or external resistor for the base pump current.
// - the pump current multiplier is one plus bits 11..10.
// - bits 16..12 set a phase offset of 22.5 degrees times that value over the multiplier.
// - bit 17 gives the phase offset a negative sign when set.
// - the reference reaching the phase detector is scaled by two, one, one half or one quarter.
// - the status output drives a selectable signal, lock detect by default.
// - the numerator joins integer and modulus so the oscillator runs at 2 x pfd x (int + num/mod).
`timescale 1ns/1ps
module sfd_regs
  import sfd_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic prog_clk_i,
  input wire logic prog_data_i,
  input wire logic prog_latch_i,
  input wire logic [FRAC_W-1:0] fractional_modulus_i,
  input wire logic lock_detect_i,
  input wire logic aux_status_i,
  output logic word_accepted_o,
  output logic [FRAC_W-1:0] fractional_numerator_o,
  output logic frac_out_of_range_o,
  output logic dither_on_o,
  output logic [3:0] dither_magnitude_o,
  output logic [DV_W-1:0] dither_restart_o,
  output logic pump_base_external_o,
  output logic [2:0] pump_current_multiplier_o,
  output logic [OFS_W-1:0] phase_offset_multiplier_o,
  output logic phase_offset_negative_o,
  output logic [PHASE_W-1:0] phase_offset_tenths_o,
  output logic ref_double_o,
  output logic [1:0] ref_halvings_o,
  output logic status_mux_output_o
);

  // ----------------------------------------
  // serial word reception
  // ----------------------------------------
  logic [WORD_W-1:0] word;
  logic word_valid;

  sfd_prog_rx u_rx (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .prog_clk_i(prog_clk_i),
    .prog_data_i(prog_data_i),
    .prog_latch_i(prog_latch_i),
    .word_o(word),
    .word_valid_o(word_valid)
  );

  logic [CTRL_W-1:0] code;
  assign code = word[CTRL_W-1:0];

  // ----------------------------------------
  // code decode
  // ----------------------------------------
  // one strobe per register, high only in the cycle the received word is valid
  logic load_frac;
  logic load_dith;
  logic load_pump;

  assign load_frac = word_valid && (code == CODE_FRAC);
  assign load_dith = word_valid && (code == CODE_DITH);
  assign load_pump = word_valid && (code == CODE_PUMP);

  // ----------------------------------------
  // word registers
  // ----------------------------------------
  logic [WORD_W-1:0] frac_word_q;
  logic [WORD_W-1:0] dith_word_q;
  logic [WORD_W-1:0] pump_word_q;

  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      frac_word_q <= FRAC_WORD_RST;
    else if (load_frac)
      frac_word_q <= word;
  end

  // reset value carries dither on and restart one
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      dith_word_q <= DITH_WORD_RST;
    else if (load_dith)
      dith_word_q <= word;
  end

  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      pump_word_q <= PUMP_WORD_RST;
    else if (load_pump)
      pump_word_q <= word;
  end

  // words for other codes belong to other registers and are dropped here
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      word_accepted_o <= 1'b0;
    else
      word_accepted_o <= load_frac || load_dith || load_pump;
  end

  // ----------------------------------------
  // fractional divide fields
  // ----------------------------------------
  // unassigned bits are stored but never used
  assign fractional_numerator_o = frac_word_q[FRAC_LSB +: FRAC_W];

  // flags a numerator that breaks num < mod, or a zero modulus
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      frac_out_of_range_o <= 1'b0;
    else
      frac_out_of_range_o <= (fractional_modulus_i == '0)
        || (frac_word_q[FRAC_LSB +: FRAC_W] >= fractional_modulus_i);
  end

  // ----------------------------------------
  // dither fields
  // ----------------------------------------
  assign dither_on_o = dith_word_q[DEN_POS];
  assign dither_restart_o = dith_word_q[DV_LSB +: DV_W];

  // code 00 is the largest magnitude, code 11 the smallest
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      dither_magnitude_o <= DMAG_TOP;
    else
    begin
      unique case (dith_word_q[DMAG_LSB +: DMAG_W])
        2'h0: dither_magnitude_o <= DMAG_TOP;
        2'h1: dither_magnitude_o <= 4'h7;
        2'h2: dither_magnitude_o <= 4'h3;
        2'h3: dither_magnitude_o <= 4'h1;
      endcase
    end
  end

  // ----------------------------------------
  // charge pump fields
  // ----------------------------------------
  logic [MULT_W-1:0] mult_code;
  logic [OFS_W-1:0] ofs;
  logic [PHASE_W-1:0] phase_raw;

  assign mult_code = pump_word_q[MULT_LSB +: MULT_W];
  assign ofs = pump_word_q[OFS_LSB +: OFS_W];
  assign pump_base_external_o = pump_word_q[BIAS_RESISTOR_POS];
  assign phase_offset_multiplier_o = ofs;
  assign phase_offset_negative_o = pump_word_q[SIGN_POS];

  // registered so it changes on the same edge as the offset result below
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      pump_current_multiplier_o <= 3'h1;
    else
      pump_current_multiplier_o <= {1'b0, mult_code} + 3'h1;
  end

  // offset in tenths of a degree: 225 x ofs over the multiplier
  assign phase_raw = PHASE_W'(ofs) * PHASE_W'(OFS_STEP_TENTHS);

  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      phase_offset_tenths_o <= '0;
    else
    begin
      unique case (mult_code)
        2'h0: phase_offset_tenths_o <= phase_raw;
        2'h1: phase_offset_tenths_o <= phase_raw >> 1;
        2'h2: phase_offset_tenths_o <= phase_raw / PHASE_W'(3);
        2'h3: phase_offset_tenths_o <= phase_raw >> 2;
      endcase
    end
  end

  // ----------------------------------------
  // reference scaling
  // ----------------------------------------
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      ref_double_o <= 1'b0;
      ref_halvings_o <= 2'h0;
    end
    else
    begin
      unique case (sfd_ref_t'(pump_word_q[REF_LSB +: REF_W]))
        SFD_REF_X2:
        begin
          ref_double_o <= 1'b1;
          ref_halvings_o <= 2'h0;
        end
        SFD_REF_X1:
        begin
          ref_double_o <= 1'b0;
          ref_halvings_o <= 2'h0;
        end
        SFD_REF_HALF:
        begin
          ref_double_o <= 1'b0;
          ref_halvings_o <= 2'h1;
        end
        SFD_REF_QUARTER:
        begin
          ref_double_o <= 1'b0;
          ref_halvings_o <= 2'h2;
        end
      endcase
    end
  end

  // ----------------------------------------
  // status multiplexer
  // ----------------------------------------
  // lock detect comes from the analog loop, so it is synchronised
  logic [SYNC_STAGES-1:0] lock_sync_q;
  logic lock_lvl_q;

  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      lock_sync_q <= '0;
    else
      lock_sync_q <= {lock_sync_q[SYNC_STAGES-2:0], lock_detect_i};
  end

  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      lock_lvl_q <= 1'b0;
    else if (lock_sync_q[1] == lock_sync_q[2])
      lock_lvl_q <= lock_sync_q[2];
  end

  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      status_mux_output_o <= 1'b0;
    else
    begin
      unique case (sfd_mux_t'(pump_word_q[MUX_LSB +: MUX_W]))
        SFD_MUX_LOCK: status_mux_output_o <= lock_lvl_q;
        SFD_MUX_HIGH: status_mux_output_o <= 1'b1;
        SFD_MUX_LOW: status_mux_output_o <= 1'b0;
        SFD_MUX_SIGN: status_mux_output_o <= pump_word_q[SIGN_POS];
        SFD_MUX_EXTRES: status_mux_output_o <= pump_word_q[BIAS_RESISTOR_POS];
        SFD_MUX_DITHER: status_mux_output_o <= dith_word_q[DEN_POS];
        SFD_MUX_AUX: status_mux_output_o <= aux_status_i;
        SFD_MUX_RANGE: status_mux_output_o <= frac_out_of_range_o;
      endcase
    end
  end

endmodule

// ===== test/sfd_regs_chk.sv
`timescale 1ns/1ps
module sfd_regs_chk
  import sfd_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic prog_latch_i,
  input wire logic [FRAC_W-1:0] fractional_modulus_i,
  input wire logic word_accepted_o,
  input wire logic [FRAC_W-1:0] fractional_numerator_o,
  input wire logic frac_out_of_range_o,
  input wire logic dither_on_o,
  input wire logic [3:0] dither_magnitude_o,
  input wire logic pump_base_external_o,
  input wire logic [2:0] pump_current_multiplier_o,
  input wire logic [OFS_W-1:0] phase_offset_multiplier_o,
  input wire logic [PHASE_W-1:0] phase_offset_tenths_o,
  input wire logic ref_double_o,
  input wire logic [1:0] ref_halvings_o
);
  logic bad_c;
  assign bad_c = (fractional_modulus_i == '0) || (fractional_numerator_o >= fractional_modulus_i);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  a_accept_pulse: assert property (word_accepted_o |=> !word_accepted_o)
    else $error("accept pulse longer than one cycle");
  a_accept_latch: assert property (word_accepted_o |-> $past(prog_latch_i, 3))
    else $error("word accepted without a latch");
  a_regs_hold: assert property (!word_accepted_o |-> $stable(fractional_numerator_o) && $stable(dither_on_o)
    && $stable(pump_base_external_o))
    else $error("register changed without a word");
  a_range_flag: assert property (frac_out_of_range_o == $past(bad_c))
    else $error("range flag wrong");
  a_offset_calc: assert property (phase_offset_tenths_o ==
    PHASE_W'((225 * $past(phase_offset_multiplier_o)) / pump_current_multiplier_o))
    else $error("phase offset wrong");
  a_mag_set: assert property (dither_magnitude_o inside {4'hf, 4'h7, 4'h3, 4'h1})
    else $error("dither magnitude illegal");
  a_mult_span: assert property (pump_current_multiplier_o inside {[3'h1:3'h4]})
    else $error("multiplier out of span");
  a_ref_scale: assert property (!(ref_double_o && ref_halvings_o != 2'h0) && ref_halvings_o != 2'h3)
    else $error("reference scale illegal");
  c_accept: cover property (word_accepted_o);
  c_range: cover property (frac_out_of_range_o);
  c_double: cover property (ref_double_o);
endmodule

// ===== test/sfd_host.sv
`timescale 1ns/1ps
module sfd_host (
  input wire logic clock_i,
  output logic prog_clk_o,
  output logic prog_data_o,
  output logic prog_latch_o
);
  initial
  begin
    prog_clk_o = 1'b0;
    prog_data_o = 1'b0;
    prog_latch_o = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask

  // msb first, every level held four clocks or more
  task automatic send(input logic [23:0] word);
    for (int i = 23; i >= 0; i--)
    begin
      prog_data_o = word[i];
      wait_clk(4);
      prog_clk_o = 1'b1;
      wait_clk(4);
      prog_clk_o = 1'b0;
    end
    // released data line shows the inverse of its last bit
    prog_data_o = ~word[0];
    wait_clk(4);
    prog_latch_o = 1'b1;
    wait_clk(8);
    prog_latch_o = 1'b0;
    wait_clk(6);
  endtask
endmodule

// ===== test/sfd_regs_tb.sv
`timescale 1ns/1ps
module sfd_regs_tb
  import sfd_pkg::*;
;
  logic clock_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic lock_detect_i = 1'b0;
  logic aux_status_i = 1'b0;
  logic [FRAC_W-1:0] fractional_modulus_i = 11'h600;
  logic prog_clk_i, prog_data_i, prog_latch_i, word_accepted_o, frac_out_of_range_o, dither_on_o;
  logic pump_base_external_o, phase_offset_negative_o, ref_double_o, status_mux_output_o;
  logic [FRAC_W-1:0] fractional_numerator_o;
  logic [3:0] dither_magnitude_o;
  logic [DV_W-1:0] dither_restart_o;
  logic [2:0] pump_current_multiplier_o;
  logic [OFS_W-1:0] phase_offset_multiplier_o;
  logic [PHASE_W-1:0] phase_offset_tenths_o;
  logic [1:0] ref_halvings_o;
  int error_cnt = 0;
  int checks = 0;
  int acc_cnt = 0;
  int cyc = 0;

  always #2.5 clock_i = ~clock_i;

  sfd_host u_host (.clock_i, .prog_clk_o(prog_clk_i), .prog_data_o(prog_data_i), .prog_latch_o(prog_latch_i));
  sfd_regs u_dut (.clock_i, .rst_b_i, .prog_clk_i, .prog_data_i, .prog_latch_i, .fractional_modulus_i,
    .lock_detect_i, .aux_status_i, .word_accepted_o, .fractional_numerator_o, .frac_out_of_range_o, .dither_on_o,
    .dither_magnitude_o, .dither_restart_o, .pump_base_external_o, .pump_current_multiplier_o,
    .phase_offset_multiplier_o, .phase_offset_negative_o, .phase_offset_tenths_o, .ref_double_o,
    .ref_halvings_o, .status_mux_output_o);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic final_report();
    if (error_cnt == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
    checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic w6();
    repeat (6) @(posedge clock_i);
    #1;
  endtask

  function automatic logic [23:0] pump_w(logic [1:0] rf, logic ext, logic neg, logic [1:0] m, logic [2:0] mx);
    return {2'h0, rf, 1'b0, ext, neg, 5'h1f, m, mx, 4'h0, CODE_PUMP};
  endfunction

  always @(posedge clock_i)
  begin
    cyc++;
    if (word_accepted_o === 1'b1)
      acc_cnt++;
    if (cyc == 10000)
    begin
      error_cnt++;
      final_report();
    end
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    chk("numerator", 24'd768, fractional_numerator_o);
    chk("dither on", 24'h1, dither_on_o);
    chk("magnitude", 24'd15, dither_magnitude_o);
    chk("restart", 24'h1, dither_restart_o);
    chk("multiplier", 24'h1, pump_current_multiplier_o);
  endtask

  task automatic t_frac();
    int n;
    n = acc_cnt;
    u_host.send({10'h0, 11'h5ff, CODE_FRAC});
    chk("numerator", 24'h5ff, fractional_numerator_o);
    chk("range flag", 24'h0, frac_out_of_range_o);
    fractional_modulus_i = 11'h5ff;
    w6();
    chk("range flag", 24'h1, frac_out_of_range_o);
    u_host.send({10'h0, 11'h0aa, 3'h1});
    chk("numerator", 24'h5ff, fractional_numerator_o);
    chk("accepts", n + 1, acc_cnt);
  endtask

  task automatic t_dith();
    logic [3:0] mag [4] = '{4'hf, 4'h7, 4'h3, 4'h1};
    for (int c = 0; c < 4; c++)
    begin
      u_host.send({1'b0, c[1:0], c[0], 17'h1 << (c * 4), CODE_DITH});
      chk("magnitude", mag[c], dither_magnitude_o);
      chk("dither on", c[0], dither_on_o);
      chk("restart", 17'h1 << (c * 4), dither_restart_o);
    end
  endtask

  task automatic t_pump();
    logic [2:0] mx [4] = '{3'h1, 3'h2, 3'h6, 3'h3};
    aux_status_i = 1'b1;
    for (int c = 0; c < 4; c++)
    begin
      u_host.send(pump_w(c[1:0], c[0], c[1], c[1:0], mx[c]));
      chk("multiplier", c + 1, pump_current_multiplier_o);
      chk("tenths", 6975 / (c + 1), phase_offset_tenths_o);
      chk("offset", 24'h1f, phase_offset_multiplier_o);
      chk("negative", c[1], phase_offset_negative_o);
      chk("external", c[0], pump_base_external_o);
      chk("ref double", c == 0, ref_double_o);
      chk("halvings", c == 0 ? 0 : c - 1, ref_halvings_o);
      chk("status", c != 1, status_mux_output_o);
    end
    u_host.send(pump_w(2'h1, 1'b0, 1'b0, 2'h0, 3'h0));
    lock_detect_i = 1'b1;
    w6();
    chk("status", 24'h1, status_mux_output_o);
    lock_detect_i = 1'b0;
    w6();
    chk("status", 24'h0, status_mux_output_o);
  endtask

  // status sources not reached above: resistor select, dither enable, range flag
  task automatic t_mux();
    u_host.send(pump_w(2'h1, 1'b0, 1'b0, 2'h0, 3'h4));
    chk("status", 24'h0, status_mux_output_o);
    u_host.send(pump_w(2'h1, 1'b1, 1'b0, 2'h0, 3'h4));
    chk("status", 24'h1, status_mux_output_o);
    u_host.send(pump_w(2'h1, 1'b0, 1'b0, 2'h0, 3'h5));
    chk("status", 24'h1, status_mux_output_o);
    u_host.send(pump_w(2'h1, 1'b0, 1'b0, 2'h0, 3'h7));
    chk("status", 24'h1, status_mux_output_o);
    fractional_modulus_i = 11'h600;
    w6();
    chk("status", 24'h0, status_mux_output_o);
  endtask

  initial
  begin
    repeat (2) @(posedge clock_i);
    #1;
    rst_b_i = 1'b1;
    t_reset();
    t_frac();
    t_dith();
    t_pump();
    t_mux();
    final_report();
  end
endmodule

bind sfd_regs sfd_regs_chk u_chk (.clock_i, .rst_b_i, .prog_latch_i, .fractional_modulus_i, .word_accepted_o,
  .fractional_numerator_o, .frac_out_of_range_o, .dither_on_o, .dither_magnitude_o, .pump_base_external_o,
  .pump_current_multiplier_o, .phase_offset_multiplier_o, .phase_offset_tenths_o, .ref_double_o, .ref_halvings_o);
